//--- tb/remote_node.sv
// Remote serial node: sends one 55h sync character or holds the line low
`timescale 1ns/1ps
module remote_node (
	// Clock
	input wire logic core_clk,
	// Commands from the bench
	input wire logic send,
	input wire logic hold_low,
	input wire logic [15:0] bit_cycles,
	// Line and status
	output logic rx_line,
	output logic busy
);
	logic [9:0] frame = 10'h3FF;
	logic [15:0] cnt = 16'h0000;
	logic [3:0] idx = 4'h0;
	initial busy = 1'b0;
	// sync field 55h: start, 55h LSB first, stop
	always @(posedge core_clk)
	begin
		if (send && !busy)
		begin
			busy <= 1'b1;
			frame <= {1'b1, 8'h55, 1'b0};
			idx <= 4'h0;
			cnt <= 16'h0000;
		end
		else if (busy)
		begin
			if (cnt == bit_cycles - 16'h0001)
			begin
				cnt <= 16'h0000;
				busy <= (idx != 4'h9);
				idx <= idx + 4'h1;
			end
			else
				cnt <= cnt + 16'h0001;
		end
	end
	// Idle line marks high, as a released pulled-up receive line does
	assign rx_line = hold_low ? 1'b0 : (busy ? frame[idx] : 1'b1);
endmodule

//--- tb/tb_top.sv
// Self-checking bench for the baud control block
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin $display("unexpected %s exp %h got %h", n, e, g); err_total++; end end
module tb_top;
	import baud_ctl_pkg::*;
	logic core_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic clk_en = 1'b1;
	logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [31:0] wdata = '0, rdata;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic sync_mode = 0, rx_busy = 0, tx_serial = 1, sclk_raw = 0;
	logic rx_pin, tx_pin_q, sclk_o, sclk_oe, baud_tick_q, irq_q;
	logic send = 0, hold_low = 0, node_busy;
	logic [15:0] bit_cycles = 16'h0014;
	logic [31:0] rd;
	logic [1:0] rs;
	int err_total = 0, total_checks = 0;
	always #2.5 core_clk = ~core_clk;
	baud_control dut (.core_clk(core_clk), .sys_rst(sys_rst),
		.clk_en(clk_en), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .sync_mode(sync_mode), .rx_busy(rx_busy),
		.tx_serial(tx_serial), .sclk_raw(sclk_raw), .rx_pin(rx_pin),
		.tx_pin_q(tx_pin_q), .sync_serial_clock_pin_o(sclk_o),
		.sync_serial_clock_pin_oe(sclk_oe), .baud_tick_q(baud_tick_q),
		.irq_q(irq_q));
	remote_node node (.core_clk(core_clk), .send(send),
		.hold_low(hold_low), .bit_cycles(bit_cycles), .rx_line(rx_pin),
		.busy(node_busy));
	task automatic results();
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic hang();
		err_total++;
		results();
	endtask
	// Write one word; ready and response sampled at the handshake edge
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
		int n;
		@(posedge core_clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		for (n = 0; n < 100; n++)
		begin
			@(posedge core_clk);
			if (awvalid && awready) awvalid <= 0;
			if (wvalid && wready) wvalid <= 0;
			if (bvalid) break;
		end
		if (n == 100) hang();
		bready <= 0;
		`CHK("bresp", RESP_OK, bresp)
	endtask
	task automatic rdx(input logic [ADDR_W-1:0] a);
		int n;
		@(posedge core_clk);
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		for (n = 0; n < 100; n++)
		begin
			@(posedge core_clk);
			if (arvalid && arready) arvalid <= 0;
			if (rvalid) break;
		end
		if (n == 100) hang();
		rd = rdata;
		rs = rresp;
		rready <= 0;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	// Reset value, unused bits and width bit
	task automatic t_ctrl();
		rdx(OFF_CTRL);
		`CHK("ctrl reset", {24'h0, CTRL_RST}, rd)
		wr(OFF_CTRL, 32'h0000_002C);
		rdx(OFF_CTRL);
		`CHK("unused bits", 32'h0000_0048, rd)
		rx_busy <= 1;
		wr(OFF_CTRL, 32'h0000_0000);
		rdx(OFF_CTRL);
		`CHK("rx idle", 32'h0000_0000, rd)
		rx_busy <= 0;
		rdx(5'h10);
		`CHK("unmapped", RESP_SLVERR, rs)
	endtask
	// Divider period for narrow and wide counting
	task automatic period(input logic [16:0] exp);
		int n;
		for (n = 0; n < 2000 && baud_tick_q !== 1'b1; n++) cyc(1);
		for (n = 1; n < 2000; n++)
		begin
			cyc(1);
			if (baud_tick_q === 1'b1) break;
		end
		`CHK("tick period", exp, n[16:0])
	endtask
	task automatic t_div();
		int n;
		wr(OFF_DIV, 32'h0000_0103);
		cyc(2);
		period(17'h4);
		wr(OFF_CTRL, 32'h0000_0008);
		cyc(2);
		period(17'h104);
		// Enable low freezes the divider just after a tick, so none follows
		clk_en <= 0;
		cyc(1);
		for (n = 0; n < 300 && baud_tick_q !== 1'b1; n++) cyc(1);
		clk_en <= 1;
		`CHK("frozen tick", 300, n)
	endtask
	// Idle polarity in both modes
	task automatic t_pol();
		wr(OFF_CTRL, 32'h0000_0010);
		cyc(2);
		`CHK("tx idle low", 1'b0, tx_pin_q)
		`CHK("clk oe async", 1'b0, sclk_oe)
		wr(OFF_CTRL, 32'h0000_0000);
		cyc(2);
		`CHK("tx idle high", 1'b1, tx_pin_q)
		sync_mode <= 1;
		wr(OFF_CTRL, 32'h0000_0012);
		wr(OFF_MASK, 32'h0000_0007);
		cyc(2);
		`CHK("clk idle high", 1'b1, sclk_o)
		`CHK("clk oe sync", 1'b1, sclk_oe)
		hold_low <= 1;
		cyc(4);
		hold_low <= 0;
		rdx(OFF_STAT);
		`CHK("sync wake", 32'h0, rd)
		wr(OFF_CTRL, 32'h0000_0000);
		cyc(2);
		`CHK("clk idle low", 1'b0, sclk_o)
		sync_mode <= 0;
	endtask
	// Wake-up edge interrupt, self-clear and write-one clear
	task automatic t_wake();
		wr(OFF_CTRL, 32'h0000_0002);
		hold_low <= 1;
		cyc(4);
		`CHK("wake irq", 1'b1, irq_q)
		hold_low <= 0;
		cyc(4);
		rdx(OFF_CTRL);
		`CHK("wake clear", 32'h0000_0040, rd)
		rdx(OFF_STAT);
		`CHK("wake stat", 32'h1, rd)
		wr(OFF_STAT, 32'h1);
		cyc(2);
		`CHK("irq cleared", 1'b0, irq_q)
		hold_low <= 1;
		cyc(4);
		hold_low <= 0;
		`CHK("not watched", 1'b0, irq_q)
	endtask
	// Auto-baud on a sync character, then an overflow
	task automatic abd(input logic [15:0] bc, input logic [31:0] c);
		int n;
		bit_cycles <= bc;
		wr(OFF_CTRL, c);
		send <= 1;
		cyc(1);
		send <= 0;
		// The node shows busy only from the edge after it took send
		cyc(1);
		for (n = 0; n < 5000 && node_busy !== 1'b0; n++) cyc(1);
		if (n == 5000) hang();
		cyc(4);
	endtask
	task automatic t_abd();
		wr(OFF_STAT, 32'h7);
		abd(16'h0014, 32'h0000_0009);
		rdx(OFF_DIV);
		`CHK("measured", 32'h0000_0014, rd)
		rdx(OFF_CTRL);
		`CHK("abd clear", 32'h0000_0048, rd)
		rdx(OFF_STAT);
		`CHK("abd done", 32'h2, rd)
		wr(OFF_STAT, 32'h7);
		abd(16'd300, 32'h0000_0001);
		rdx(OFF_CTRL);
		`CHK("overflow", 32'h0000_00C0, rd)
		rdx(OFF_STAT);
		`CHK("ovf stat", 32'h4, rd)
	endtask
	initial
	begin
		cyc(6);
		sys_rst <= 0;
		cyc(1);
		t_ctrl();
		t_div();
		t_pol();
		t_wake();
		t_abd();
		results();
	end
endmodule

//--- verilog/autobaud_meter.sv
// Measures the bit time of a 55h sync field on the receive pin
`timescale 1ns/1ps
module autobaud_meter (
	// Clock, reset, enable
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	// Control
	input wire logic arm,
	input wire logic wide,
	input wire logic rx_fall,
	// Results
	output logic done_q,
	output logic ovf_q,
	output logic [15:0] result_q
);
	import baud_ctl_pkg::*;

	meter_state_t state_q, state_d;
	logic [MEAS_W-1:0] cnt_q, cnt_d;
	logic [2:0] edge_q, edge_d;
	logic done_d, ovf_d, over;
	logic [15:0] result_d;

	// Sync field has five falling edges over eight bit times
	always_comb
	begin
		state_d = state_q;
		cnt_d = cnt_q;
		edge_d = edge_q;
		done_d = 1'b0;
		ovf_d = 1'b0;
		result_d = result_q;
		over = wide ? (&cnt_q) : cnt_q[NARROW_LIMIT_BIT];
		unique case (state_q)
			M_IDLE:
				if (arm && !done_q && !ovf_q)
					state_d = M_WAIT;
			M_WAIT:
				if (!arm)
					state_d = M_IDLE;
				else if (rx_fall)
				begin
					state_d = M_RUN;
					cnt_d = '0;
					edge_d = '0;
				end
			M_RUN:
			begin
				cnt_d = cnt_q + 1'b1;
				if (!arm)
					state_d = M_IDLE;
				else if (over)
				begin
					// Too slow for the selected width
					ovf_d = 1'b1;
					state_d = M_IDLE;
				end
				else if (rx_fall)
				begin
					edge_d = edge_q + 1'b1;
					if (edge_q == SYNC_LAST_EDGE)
					begin
						done_d = 1'b1;
						result_d = cnt_d[MEAS_W-1:MEAS_SHIFT];
						state_d = M_IDLE;
					end
				end
			end
			default:
				state_d = M_IDLE;
		endcase
	end

	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			state_q <= M_IDLE;
			cnt_q <= '0;
			edge_q <= '0;
			done_q <= 1'b0;
			ovf_q <= 1'b0;
			result_q <= '0;
		end
		else if (clk_en)
		begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			edge_q <= edge_d;
			done_q <= done_d;
			ovf_q <= ovf_d;
			result_q <= result_d;
		end
	end
endmodule

//--- verilog/baud_control.sv
// Baud control register, line polarity, wake-up and auto-baud
`timescale 1ns/1ps
module baud_control (
	// Clock, reset, enable
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	// AXI4-Lite slave
	input wire logic [baud_ctl_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [baud_ctl_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Serial core side
	input wire logic sync_mode,
	input wire logic rx_busy,
	input wire logic tx_serial,
	input wire logic sclk_raw,
	// Pins
	input wire logic rx_pin,
	output logic tx_pin_q,
	output logic sync_serial_clock_pin_o,
	output logic sync_serial_clock_pin_oe,
	// Baud tick and interrupt
	output logic baud_tick_q,
	output logic irq_q
);
	import baud_ctl_pkg::*;

	logic aw_got_q, aw_got_d, w_got_q, w_got_d;
	logic [ADDR_W-1:0] awaddr_q, awaddr_d;
	logic [31:0] wdata_q, wdata_d;
	logic [3:0] wstrb_q, wstrb_d;
	logic awready_d, wready_d, bvalid_d, arready_d, rvalid_d;
	logic [1:0] bresp_d, rresp_d;
	logic [31:0] rdata_d;
	logic wr_go, wr_ctrl, wr_div, wr_stat, wr_mask;

	logic [7:0] ctrl_q, ctrl_d;
	logic [15:0] div_q, div_d;
	logic [STAT_W-1:0] stat_q, stat_d, mask_q, mask_d;
	logic rx_prev_q, rx_prev_d, wake_fell_q, wake_fell_d;
	logic tx_d, sclk_d, sclk_oe_d, irq_d;
	logic rx_fall, rx_rise, abd_done, abd_ovf;
	logic [15:0] abd_result;

	// A write commits once both address and data are held
	assign wr_go = aw_got_q && w_got_q && !s_axi_bvalid;
	assign wr_ctrl = wr_go && awaddr_q == OFF_CTRL && wstrb_q[0];
	assign wr_div = wr_go && awaddr_q == OFF_DIV;
	assign wr_stat = wr_go && awaddr_q == OFF_STAT && wstrb_q[0];
	assign wr_mask = wr_go && awaddr_q == OFF_MASK && wstrb_q[0];

	// Bus handshakes; address and data are taken in either order
	always_comb
	begin
		aw_got_d = aw_got_q;
		w_got_d = w_got_q;
		awaddr_d = awaddr_q;
		wdata_d = wdata_q;
		wstrb_d = wstrb_q;
		bvalid_d = s_axi_bvalid;
		bresp_d = s_axi_bresp;
		rvalid_d = s_axi_rvalid;
		rresp_d = s_axi_rresp;
		rdata_d = s_axi_rdata;
		if (s_axi_awvalid && s_axi_awready)
		begin
			aw_got_d = 1'b1;
			awaddr_d = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			w_got_d = 1'b1;
			wdata_d = s_axi_wdata;
			wstrb_d = s_axi_wstrb;
		end
		if (wr_go)
		begin
			aw_got_d = 1'b0;
			w_got_d = 1'b0;
			bvalid_d = 1'b1;
			bresp_d = (awaddr_q == OFF_CTRL || awaddr_q == OFF_DIV ||
				awaddr_q == OFF_STAT || awaddr_q == OFF_MASK) ?
				RESP_OK : RESP_SLVERR;
		end
		else if (s_axi_bvalid && s_axi_bready)
			bvalid_d = 1'b0;
		if (s_axi_rvalid && s_axi_rready)
			rvalid_d = 1'b0;
		if (s_axi_arvalid && s_axi_arready)
		begin
			rvalid_d = 1'b1;
			rresp_d = RESP_OK;
			rdata_d = 32'h00000000;
			unique case (s_axi_araddr)
				OFF_CTRL: rdata_d[7:0] = ctrl_q;
				OFF_DIV: rdata_d[15:0] = div_q;
				OFF_STAT: rdata_d[STAT_W-1:0] = stat_q;
				OFF_MASK: rdata_d[STAT_W-1:0] = mask_q;
				default: rresp_d = RESP_SLVERR;
			endcase
		end
		// One write and one read outstanding at most
		awready_d = !aw_got_d && !bvalid_d;
		wready_d = !w_got_d && !bvalid_d;
		arready_d = !rvalid_d;
	end

	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			aw_got_q <= 1'b0;
			w_got_q <= 1'b0;
			awaddr_q <= '0;
			wdata_q <= 32'h00000000;
			wstrb_q <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OK;
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp <= RESP_OK;
			s_axi_rdata <= 32'h00000000;
		end
		else if (clk_en)
		begin
			aw_got_q <= aw_got_d;
			w_got_q <= w_got_d;
			awaddr_q <= awaddr_d;
			wdata_q <= wdata_d;
			wstrb_q <= wstrb_d;
			s_axi_awready <= awready_d;
			s_axi_wready <= wready_d;
			s_axi_bvalid <= bvalid_d;
			s_axi_bresp <= bresp_d;
			s_axi_arready <= arready_d;
			s_axi_rvalid <= rvalid_d;
			s_axi_rresp <= rresp_d;
			s_axi_rdata <= rdata_d;
		end
	end

	// Receive pin edges, the pin counts as synchronous
	assign rx_fall = rx_prev_q && !rx_pin;
	assign rx_rise = !rx_prev_q && rx_pin;

	autobaud_meter u_meter (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.clk_en(clk_en),
		.arm(ctrl_q[B_ABD] && !sync_mode),
		.wide(ctrl_q[B_WIDE]),
		.rx_fall(rx_fall),
		.done_q(abd_done),
		.ovf_q(abd_ovf),
		.result_q(abd_result)
	);

	// Control, divisor and interrupt state
	always_comb
	begin
		ctrl_d = ctrl_q;
		div_d = div_q;
		stat_d = stat_q;
		mask_d = mask_q;
		rx_prev_d = rx_pin;
		wake_fell_d = wake_fell_q;
		if (wr_ctrl)
		begin
			ctrl_d[B_POL] = wdata_q[B_POL];
			ctrl_d[B_WIDE] = wdata_q[B_WIDE];
			ctrl_d[B_WAKE] = wdata_q[B_WAKE];
			ctrl_d[B_ABD] = wdata_q[B_ABD];
			// Overflow flag is cleared by writing zero
			if (!wdata_q[B_OVF])
				ctrl_d[B_OVF] = 1'b0;
		end
		if (wr_div && wstrb_q[0])
			div_d[7:0] = wdata_q[7:0];
		if (wr_div && wstrb_q[1])
			div_d[15:8] = wdata_q[15:8];
		if (wr_mask)
			mask_d = wdata_q[STAT_W-1:0];
		// Status bits clear on a written one
		if (wr_stat)
			stat_d = stat_q & ~wdata_q[STAT_W-1:0];
		if (abd_done)
		begin
			div_d = abd_result;
			ctrl_d[B_ABD] = 1'b0;
			stat_d[S_ABD] = 1'b1;
		end
		// overflow flag, set wins over clear
		if (abd_ovf && !sync_mode)
		begin
			ctrl_d[B_OVF] = 1'b1;
			ctrl_d[B_ABD] = 1'b0;
			stat_d[S_OVF] = 1'b1;
		end
		// wake edge watch; sync mode ignores it
		if (!ctrl_q[B_WAKE] || sync_mode)
			wake_fell_d = 1'b0;
		else if (rx_fall)
		begin
			stat_d[S_WAKE] = 1'b1;
			wake_fell_d = 1'b1;
		end
		else if (wake_fell_q && rx_rise)
		begin
			ctrl_d[B_WAKE] = 1'b0;
			wake_fell_d = 1'b0;
		end
		// receive idle flag tracks the receiver, held low in sync mode
		ctrl_d[B_RXIDLE] = !sync_mode && !rx_busy;
		ctrl_d[B_RSV5] = 1'b0;
		ctrl_d[B_RSV2] = 1'b0;
		tx_d = tx_serial ^ (ctrl_d[B_POL] && !sync_mode);
		sclk_d = sclk_raw ^ (ctrl_d[B_POL] && sync_mode);
		sclk_oe_d = sync_mode;
		irq_d = |(stat_d & mask_d);
	end

	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			ctrl_q <= CTRL_RST;
			div_q <= DIV_RST;
			stat_q <= STAT_RST;
			mask_q <= STAT_RST;
			rx_prev_q <= 1'b1;
			wake_fell_q <= 1'b0;
			tx_pin_q <= 1'b1;
			sync_serial_clock_pin_o <= 1'b0;
			sync_serial_clock_pin_oe <= 1'b0;
			irq_q <= 1'b0;
		end
		else if (clk_en)
		begin
			ctrl_q <= ctrl_d;
			div_q <= div_d;
			stat_q <= stat_d;
			mask_q <= mask_d;
			rx_prev_q <= rx_prev_d;
			wake_fell_q <= wake_fell_d;
			tx_pin_q <= tx_d;
			sync_serial_clock_pin_o <= sclk_d;
			sync_serial_clock_pin_oe <= sclk_oe_d;
			irq_q <= irq_d;
		end
	end

	// generator width from the control bit
	baud_divider #(
		.DIV_W(16)
	) u_div (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.clk_en(clk_en),
		.wide(ctrl_q[B_WIDE]),
		.divisor(div_q),
		.tick_q(baud_tick_q)
	);

	overflow_flag_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		clk_en && abd_ovf && !sync_mode |=> ctrl_q[B_OVF] && !ctrl_q[B_ABD])
		else $error("overflow did not set flag");

	idle_flag_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		clk_en && !sync_mode |=> ctrl_q[B_RXIDLE] == !$past(rx_busy))
		else $error("receive idle flag wrong");

	tx_polarity_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		clk_en && !sync_mode && tx_serial |=> tx_pin_q == !ctrl_q[B_POL])
		else $error("transmit idle polarity wrong");

	clock_polarity_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		clk_en && sync_mode && !sclk_raw ##1 clk_en && sync_mode
		|-> sync_serial_clock_pin_o == ctrl_q[B_POL] && sync_serial_clock_pin_oe)
		else $error("serial clock idle polarity wrong");

	wake_raise_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		clk_en && !sync_mode && ctrl_q[B_WAKE] && rx_fall
		|=> stat_q[S_WAKE] && wake_fell_q)
		else $error("wake edge not flagged");

	wake_clear_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		clk_en && !sync_mode && wake_fell_q && rx_rise |=> !ctrl_q[B_WAKE])
		else $error("wake enable not cleared");

	sync_wake_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		clk_en && sync_mode && rx_fall |=> !$rose(stat_q[S_WAKE]))
		else $error("wake seen in sync mode");

	measure_done_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		clk_en && abd_done |=> !ctrl_q[B_ABD] && stat_q[S_ABD])
		else $error("auto-baud not cleared on completion");

	reserved_zero_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		s_axi_rvalid && $rose(s_axi_rvalid) && $past(s_axi_araddr) == OFF_CTRL
		|-> s_axi_rdata[B_RSV5] == 1'b0 && s_axi_rdata[B_RSV2] == 1'b0)
		else $error("unused control bits read nonzero");
endmodule

//--- verilog/baud_ctl_pkg.sv
// Shared constants and types for the baud control block
package baud_ctl_pkg;
	// Register bus address width and byte offsets
	localparam int ADDR_W = 5;
	localparam logic [ADDR_W-1:0] OFF_CTRL = 5'h00;
	localparam logic [ADDR_W-1:0] OFF_DIV = 5'h04;
	localparam logic [ADDR_W-1:0] OFF_STAT = 5'h08;
	localparam logic [ADDR_W-1:0] OFF_MASK = 5'h0C;
	// Control register field positions
	localparam int B_OVF = 7;
	localparam int B_RXIDLE = 6;
	localparam int B_RSV5 = 5;
	localparam int B_POL = 4;
	localparam int B_WIDE = 3;
	localparam int B_RSV2 = 2;
	localparam int B_WAKE = 1;
	localparam int B_ABD = 0;
	// Interrupt status and mask field positions
	localparam int S_WAKE = 0;
	localparam int S_ABD = 1;
	localparam int S_OVF = 2;
	localparam int STAT_W = 3;
	// Values after reset
	localparam logic [7:0] CTRL_RST = 8'h40;
	localparam logic [15:0] DIV_RST = 16'h0000;
	localparam logic [STAT_W-1:0] STAT_RST = 3'h0;
	// Bus response codes
	localparam logic [1:0] RESP_OK = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Measurement: index, counted from 0, of the last falling edge after the first in a 55h sync field
	localparam logic [2:0] SYNC_LAST_EDGE = 3'h3;
	localparam int MEAS_W = 19;
	localparam int MEAS_SHIFT = 3;
	localparam int NARROW_LIMIT_BIT = 11;
	// Measurement states
	typedef enum logic [1:0] {
		M_IDLE = 2'b00,
		M_WAIT = 2'b01,
		M_RUN = 2'b10
	} meter_state_t;
endpackage

//--- verilog/baud_divider.sv
// Baud rate generator, 8-bit or 16-bit down counter
`timescale 1ns/1ps
module baud_divider #(
	parameter int DIV_W = 16
) (
	// Clock, reset, enable
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	// Control
	input wire logic wide,
	input wire logic [DIV_W-1:0] divisor,
	// Tick out
	output logic tick_q
);
	import baud_ctl_pkg::*;

	logic [DIV_W-1:0] cnt_q, cnt_d;
	logic tick_d;

	// Reload at zero; narrow mode ignores the divisor's upper byte
	always_comb
	begin
		tick_d = 1'b0;
		cnt_d = cnt_q - 1'b1;
		if (cnt_q == '0)
		begin
			tick_d = 1'b1;
			cnt_d = wide ? divisor : DIV_W'(divisor[7:0]);
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			cnt_q <= '0;
			tick_q <= 1'b0;
		end
		else if (clk_en)
		begin
			cnt_q <= cnt_d;
			tick_q <= tick_d;
		end
	end

	// Width select of the reload
	narrow_reload_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		clk_en && !wide && cnt_q == '0 |=> cnt_q == DIV_W'($past(divisor[7:0])))
		else $error("narrow reload used upper divisor bits");
endmodule
